// ===== acf_pkg.sv
/*
  Package for the converter channel-select and result-format block:
  register offsets, field positions, reset values and type definitions.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package acf_pkg;
  // Register byte offsets
  localparam logic [7:0] ACF_SEQ_CTRL_OFS = 8'h00;
  localparam logic [7:0] ACF_WRAP_OFS = 8'h04;
  localparam logic [7:0] ACF_FMT_OFS = 8'h08;
  localparam logic [7:0] ACF_CMD_OFS = 8'h0c;
  localparam logic [7:0] ACF_STAT_OFS = 8'h10;
  localparam logic [7:0] ACF_RAW_OFS = 8'h14;
  localparam logic [7:0] ACF_RES_OFS = 8'h18;
  // Sequence control field positions
  localparam int ACF_RJ_BIT = 7;
  localparam int ACF_SGN_BIT = 6;
  localparam int ACF_MULTI_BIT = 4;
  localparam int ACF_CODE_LSB = 0;
  // Format register: eight-bit resolution select
  localparam int ACF_RES8_BIT = 0;
  // Reset values, channel limits and raw code width
  localparam logic [7:0] ACF_SEQ_CTRL_RST = 8'h00;
  localparam logic [3:0] ACF_WRAP_RST = 4'hf;
  localparam logic [3:0] ACF_SEQ_LEN_RST = 4'h4;
  localparam logic [3:0] ACF_LAST_CHAN = 4'hf;
  localparam logic [3:0] ACF_CHAN_ZERO = 4'h0;
  localparam int ACF_RAW_W = 10;

  typedef enum logic [1:0] {
    ACF_IDLE = 2'b00,
    ACF_CONV = 2'b01,
    ACF_WAIT = 2'b10
  } acf_state_type;
endpackage

// ===== acf_fmt_if.sv
/*
  Interface carrying raw results and format controls to the formatter.
  Assumes a single clock domain; signals are plain combinational nets.
*/
`timescale 1ns/10ps
`default_nettype none
interface acf_fmt_if;
  logic [9:0] raw;
  logic res8;
  logic rjust;
  logic sgn;
  logic [15:0] word;
  modport ctrl (output raw, output res8, output rjust, output sgn,
                input word);
  modport fmt (input raw, input res8, input rjust, input sgn,
               output word);
endinterface
`default_nettype wire

// ===== acf_formatter.sv
/*
  Result formatter: places a 10-bit raw code into a 16-bit result word.
  Assumes an eight-bit result is taken from the top bits of the raw code.
*/
`timescale 1ns/10ps
`default_nettype none
module acf_formatter (
  acf_fmt_if.fmt f  // Raw code, controls and result word
);
  import acf_pkg::*;

  logic [7:0] r8;
  assign r8 = f.raw[9:2];

  always_comb begin
    f.word = 16'h0000;
    if (f.res8) begin
      if (f.rjust) begin
        f.word[7:0] = r8;
      end else begin
        // Signed coding is the offset code with the top bit inverted
        f.word[15:8] = {r8[7] ^ f.sgn, r8[6:0]};
      end
    end else begin
      if (f.rjust) begin
        f.word[9:0] = f.raw;
      end else begin
        f.word[15:6] = {f.raw[9] ^ f.sgn, f.raw[8:0]};
      end
    end
  end
endmodule
`default_nettype wire

// ===== acf_chan_step.sv
/*
  Channel stepper: next channel after the current one in a multi-channel
  sequence. Assumes the first-wrap flag is kept by the caller.
*/
`timescale 1ns/10ps
`default_nettype none
module acf_chan_step (
  input wire logic [3:0] cur,     // Current channel
  input wire logic [3:0] wrap,    // Wrap-channel limit
  input wire logic above,         // Sequence started above the limit
  output logic [3:0] nxt          // Next channel
);
  import acf_pkg::*;

  always_comb begin
    if (above) begin
      // First wrap goes past the limit up to the top channel
      nxt = (cur == ACF_LAST_CHAN) ? ACF_CHAN_ZERO : cur + 4'h1;
    end else begin
      nxt = (cur == wrap) ? ACF_CHAN_ZERO : cur + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== acf_top.sv
/*
  Channel-select and result-format block of a converter sequencer.
  Assumes an APB master, and a converter core that takes a channel with
  a one-cycle start pulse and answers with a done pulse and a raw code.
*/
// The placing of the registers and register access over APB are this design's own decisions.
// Summary of operation
// - With multi-channel clear every conversion uses the coded channel.
// - With multi-channel set channels step up from the code, wrapping to zero after the limit.
// - A sequence starting above the limit runs up to fifteen before its first wrap to zero.
// - Eight-bit left-justified results sit in bits 15:8, signed when selected.
// - Eight-bit right-justified results sit unsigned in bits 7:0.
// - Ten-bit left-justified results sit in bits 15:6, signed when selected.
// - Ten-bit right-justified results sit unsigned in bits 9:0.
// - Signed left-justified code is the unsigned code with its top bit inverted.
// - The channel code is a plain binary channel number, zero meaning channel zero.
// - A multi-channel sequence converts as many channels as the sequence length.
`timescale 1ns/10ps
`default_nettype none
module acf_top (
  input wire logic core_clk,          // System clock, 50 MHz
  input wire logic rst,               // Synchronous reset, active high
  input wire logic psel,              // APB select
  input wire logic penable,           // APB enable
  input wire logic pwrite,            // APB direction
  input wire logic [7:0] paddr,       // APB byte address
  input wire logic [31:0] pwdata,     // APB write data
  output logic [31:0] prdata,         // APB read data
  output logic pready,                // APB ready
  output logic pslverr,               // APB error on unmapped address
  output logic [3:0] conv_chan,       // Channel to the multiplexer
  output logic conv_start,            // Start pulse to the converter
  input wire logic conv_done,         // Converter finished
  input wire logic [9:0] conv_raw,    // Converter raw code
  output logic [15:0] result_word,    // Last formatted result
  output logic seq_busy               // Sequence running
);
  import acf_pkg::*;

  logic [7:0] seq_ctrl_r;
  logic [3:0] wrap_r;
  logic [3:0] seq_len_r;
  logic res8_r;
  logic [9:0] raw_r;
  logic [15:0] res_r;
  logic [3:0] chan_r;
  logic [3:0] cnt_r;
  logic above_r;
  logic [3:0] step_nxt;
  logic [31:0] rd_nxt;
  logic [31:0] prdata_r;
  logic map_ok;
  logic wr_en;
  logic go;
  logic multi_sel;
  acf_state_type state_r;
  acf_fmt_if fmt_bus ();

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign multi_sel = seq_ctrl_r[ACF_MULTI_BIT];
  // A write to the sequence control or the command register starts a run
  assign go = wr_en && map_ok &&
              (paddr == ACF_SEQ_CTRL_OFS || paddr == ACF_CMD_OFS);

  always_comb begin
    map_ok = 1'b1;
    rd_nxt = 32'h0000_0000;
    unique case (paddr)
      ACF_SEQ_CTRL_OFS: rd_nxt[7:0] = seq_ctrl_r;
      ACF_WRAP_OFS: rd_nxt[3:0] = wrap_r;
      ACF_FMT_OFS: rd_nxt = {24'h0, seq_len_r, 3'h0, res8_r};
      ACF_CMD_OFS: rd_nxt = 32'h0000_0000;
      ACF_STAT_OFS: rd_nxt = {24'h0, chan_r, cnt_r};
      ACF_RAW_OFS: rd_nxt[9:0] = raw_r;
      ACF_RES_OFS: rd_nxt[15:0] = res_r;
      default: map_ok = 1'b0;
    endcase
  end

  // Read data is latched at setup so it stands through the access phase;
  // status therefore shows its value of the setup cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_nxt;
    end else begin
      prdata_r <= 32'h0000_0000;
    end
  end
  assign prdata = prdata_r;
  assign pslverr = psel && penable && !map_ok;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      seq_ctrl_r <= ACF_SEQ_CTRL_RST;
      wrap_r <= ACF_WRAP_RST;
      seq_len_r <= ACF_SEQ_LEN_RST;
      res8_r <= 1'b0;
    end else if (wr_en && map_ok) begin
      if (paddr == ACF_SEQ_CTRL_OFS) begin
        seq_ctrl_r <= pwdata[7:0];
      end
      if (paddr == ACF_WRAP_OFS) begin
        wrap_r <= pwdata[3:0];
      end
      if (paddr == ACF_FMT_OFS) begin
        res8_r <= pwdata[ACF_RES8_BIT];
        seq_len_r <= pwdata[7:4];
      end
    end
  end

  acf_chan_step u_step (
    .cur(chan_r),
    .wrap(wrap_r),
    .above(above_r),
    .nxt(step_nxt)
  );

  // Sequencer; a new start write aborts any run in progress
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= ACF_IDLE;
      chan_r <= ACF_CHAN_ZERO;
      cnt_r <= 4'h0;
      above_r <= 1'b0;
    end else if (go) begin
      state_r <= ACF_CONV;
      // Code is a binary channel number
      chan_r <= pwdata[ACF_CODE_LSB +: 4];
      above_r <= pwdata[ACF_CODE_LSB +: 4] > wrap_r;
      cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        ACF_IDLE: state_r <= ACF_IDLE;
        ACF_CONV: state_r <= ACF_WAIT;
        ACF_WAIT: begin
          if (conv_done) begin
            // Length zero is taken as sixteen conversions
            if (cnt_r + 4'h1 == seq_len_r) begin
              state_r <= ACF_IDLE;
            end else begin
              state_r <= ACF_CONV;
            end
            cnt_r <= cnt_r + 4'h1;
            if (multi_sel) begin
              chan_r <= step_nxt;
              if (chan_r == ACF_LAST_CHAN) begin
                above_r <= 1'b0;
              end
            end  // else keep the coded channel
          end
        end
        default: state_r <= ACF_IDLE;
      endcase
    end
  end

  assign fmt_bus.raw = raw_r;
  assign fmt_bus.res8 = res8_r;
  assign fmt_bus.rjust = seq_ctrl_r[ACF_RJ_BIT];
  assign fmt_bus.sgn = seq_ctrl_r[ACF_SGN_BIT];

  acf_formatter u_fmt (
    .f(fmt_bus.fmt)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      raw_r <= 10'h000;
    end else if (state_r == ACF_WAIT && conv_done) begin
      raw_r <= conv_raw;
    end
  end

  // Result follows raw code and format settings one cycle later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      res_r <= 16'h0000;
    end else begin
      res_r <= fmt_bus.word;
    end
  end

  assign conv_chan = chan_r;
  assign conv_start = (state_r == ACF_CONV);
  assign result_word = res_r;
  assign seq_busy = (state_r != ACF_IDLE);

  property p_single_chan;
    @(posedge core_clk) disable iff (rst)
      (state_r == ACF_WAIT && conv_done && !multi_sel && !go)
        |=> $stable(chan_r);
  endproperty
  a_single_chan: assert property (p_single_chan)
    else $error("channel moved in single-channel mode");

  property p_wrap_zero;
    @(posedge core_clk) disable iff (rst)
      (state_r == ACF_WAIT && conv_done && multi_sel && !go && !above_r &&
       chan_r == wrap_r) |=> chan_r == 4'h0;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero)
    else $error("no wrap to zero after limit");

  property p_incr;
    @(posedge core_clk) disable iff (rst)
      (state_r == ACF_WAIT && conv_done && multi_sel && !go &&
       chan_r != wrap_r && chan_r != 4'hf) |=> chan_r == $past(chan_r) + 4'h1;
  endproperty
  a_incr: assert property (p_incr)
    else $error("channel did not increment");

  property p_above;
    @(posedge core_clk) disable iff (rst)
      (state_r == ACF_WAIT && conv_done && multi_sel && !go && above_r &&
       chan_r == wrap_r) |=> chan_r == $past(chan_r) + 4'h1;
  endproperty
  a_above: assert property (p_above)
    else $error("early wrap when started above limit");

  property p_r8l;
    @(posedge core_clk) disable iff (rst)
      (res8_r && !seq_ctrl_r[ACF_RJ_BIT])
        |=> res_r[7:0] == 8'h00 && res_r[14:8] == $past(raw_r[8:2]);
  endproperty
  a_r8l: assert property (p_r8l)
    else $error("eight-bit left result misplaced");

  property p_r8r;
    @(posedge core_clk) disable iff (rst)
      (res8_r && seq_ctrl_r[ACF_RJ_BIT])
        |=> res_r == {8'h00, $past(raw_r[9:2])};
  endproperty
  a_r8r: assert property (p_r8r)
    else $error("eight-bit right result wrong");

  property p_r10l;
    @(posedge core_clk) disable iff (rst)
      (!res8_r && !seq_ctrl_r[ACF_RJ_BIT])
        |=> res_r[5:0] == 6'h00 && res_r[14:6] == $past(raw_r[8:0]);
  endproperty
  a_r10l: assert property (p_r10l)
    else $error("ten-bit left result misplaced");

  property p_r10r;
    @(posedge core_clk) disable iff (rst)
      (!res8_r && seq_ctrl_r[ACF_RJ_BIT])
        |=> res_r == {6'h00, $past(raw_r)};
  endproperty
  a_r10r: assert property (p_r10r)
    else $error("ten-bit right result wrong");

  property p_sign;
    @(posedge core_clk) disable iff (rst)
      (!seq_ctrl_r[ACF_RJ_BIT])
        |=> res_r[15] == ($past(raw_r[9]) ^ $past(seq_ctrl_r[ACF_SGN_BIT]));
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign bit coding wrong");

  property p_code;
    @(posedge core_clk) disable iff (rst)
      go |=> conv_chan == $past(pwdata[3:0]) && conv_start;
  endproperty
  a_code: assert property (p_code)
    else $error("start channel not the binary code");

  property p_len;
    @(posedge core_clk) disable iff (rst)
      (state_r == ACF_WAIT && conv_done && !go && cnt_r + 4'h1 == seq_len_r)
        |=> !seq_busy;
  endproperty
  a_len: assert property (p_len)
    else $error("sequence did not end at its length");

  property p_single_rerun;
    @(posedge core_clk) disable iff (rst)
      (state_r == ACF_WAIT && conv_done && !multi_sel && !go &&
       cnt_r + 4'h1 != seq_len_r)
        |=> conv_start && conv_chan == $past(chan_r);
  endproperty
  a_single_rerun: assert property (p_single_rerun)
    else $error("single-channel run left its coded channel");

  property p_first_wrap;
    @(posedge core_clk) disable iff (rst)
      (state_r == ACF_WAIT && conv_done && multi_sel && !go && above_r &&
       chan_r == ACF_LAST_CHAN) |=> chan_r == ACF_CHAN_ZERO && !above_r;
  endproperty
  a_first_wrap: assert property (p_first_wrap)
    else $error("first wrap from fifteen did not reach zero");

  property p_len_more;
    @(posedge core_clk) disable iff (rst)
      (state_r == ACF_WAIT && conv_done && !go && cnt_r + 4'h1 != seq_len_r)
        |=> seq_busy && conv_start;
  endproperty
  a_len_more: assert property (p_len_more)
    else $error("sequence ended before its length");

  property p_zero_code;
    @(posedge core_clk) disable iff (rst)
      (go && pwdata[ACF_CODE_LSB +: 4] == 4'h0)
        |=> conv_chan == ACF_CHAN_ZERO;
  endproperty
  a_zero_code: assert property (p_zero_code)
    else $error("code zero did not select channel zero");
endmodule
`default_nettype wire

// ===== acf_conv_model.sv
/*
  Behavioural converter core on the far side of the channel selector.
  Assumes a one-cycle start pulse; answers with a one-cycle done pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module acf_conv_model (
  input wire logic core_clk,     // Clock
  input wire logic rst,          // Reset, active high
  input wire logic conv_start,   // Start pulse
  input wire logic slow,         // Long conversion when high
  input wire logic [9:0] raw_val, // Code to return
  output logic conv_done,        // Done pulse
  output logic [9:0] conv_raw    // Raw code
);
  logic [3:0] cnt_r;
  logic busy_r;
  logic [9:0] last_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      conv_done <= 1'b0;
      last_r <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        busy_r <= 1'b1;
        cnt_r <= slow ? 4'h6 : 4'h0;
      end else if (busy_r) begin
        if (cnt_r == 4'h0) begin
          busy_r <= 1'b0;
          conv_done <= 1'b1;
          last_r <= raw_val;
        end else begin
          cnt_r <= cnt_r - 4'h1;
        end
      end
    end
  end
  // Outside the done pulse the code is inverted so stale data never matches
  assign conv_raw = conv_done ? last_r : ~last_r;
endmodule
`default_nettype wire

// ===== acf_tb.sv
/*
  Self-checking bench for the channel-select and result-format block.
  Assumes the converter model and zero-wait APB answers.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import acf_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic err;
  logic pready, pslverr, conv_start, conv_done, seq_busy;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic [3:0] conv_chan;
  logic [9:0] conv_raw;
  logic [9:0] raw_val = 10'h000;
  logic [9:0] raws [3] = '{10'h200, 10'h000, 10'h2d7};
  logic [15:0] result_word;
  logic [3:0] chq [$];
  int miscompares = 0;
  int compares = 0;
  always #10 core_clk = ~core_clk;
  acf_top u_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_chan(conv_chan), .conv_start(conv_start), .conv_done(conv_done),
    .conv_raw(conv_raw), .result_word(result_word), .seq_busy(seq_busy));
  acf_conv_model u_conv (.core_clk(core_clk), .rst(rst),
    .conv_start(conv_start), .slow(slow), .raw_val(raw_val),
    .conv_done(conv_done), .conv_raw(conv_raw));
  always @(posedge core_clk) begin
    if (conv_start === 1'b1) chq.push_back(conv_chan);
  end
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_chan(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t channel %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Starts a run and checks the channel order against the stepping rules
  task automatic run(input logic [7:0] ctrl, input int n,
                     input logic [3:0] wrap);
    logic [3:0] c;
    logic above;
    chq.delete();
    apb(1'b1, ACF_SEQ_CTRL_OFS, {24'h0, ctrl});
    while (seq_busy === 1'b1) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    chk_val(32'(chq.size()), n);
    c = ctrl[3:0];
    above = c > wrap;
    for (int i = 0; i < n; i++) begin
      chk_chan(chq[i], c);
      if (ctrl[ACF_MULTI_BIT]) begin
        if (c == 4'hf) begin
          c = 4'h0;
          above = 1'b0;
        end else if (!above && c == wrap) c = 4'h0;
        else c = c + 4'h1;
      end
    end
  endtask
  // k holds eight-bit select, right justify, signed select
  function automatic logic [15:0] fexp(input logic [9:0] r,
                                       input logic [2:0] k);
    case (k[2:1])
      2'b10: fexp = {r[9:2] ^ {k[0], 7'h0}, 8'h00};
      2'b11: fexp = {8'h00, r[9:2]};
      2'b00: fexp = {r ^ {k[0], 9'h0}, 6'h00};
      default: fexp = {6'h00, r};
    endcase
  endfunction
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, ACF_SEQ_CTRL_OFS, 32'h0);
    chk_val(rd, {24'h0, ACF_SEQ_CTRL_RST});
    apb(1'b0, ACF_WRAP_OFS, 32'h0);
    chk_val(rd, {28'h0, ACF_WRAP_RST});
    apb(1'b0, ACF_FMT_OFS, 32'h0);
    chk_val(rd, {24'h0, ACF_SEQ_LEN_RST, 4'h0});
    apb(1'b1, 8'hfc, 32'h5a);
    chk_val({31'h0, err}, 32'h1);
    apb(1'b0, 8'hfc, 32'h0);
    chk_val(rd, 32'h0);
    apb(1'b1, ACF_FMT_OFS, 32'h30);
    run(8'h05, 3, 4'hf);
    run(8'h00, 3, 4'hf);
    apb(1'b1, ACF_WRAP_OFS, 32'h7);
    apb(1'b1, ACF_FMT_OFS, 32'h40);
    slow <= 1'b1;
    run(8'h16, 4, 4'h7);
    apb(1'b1, ACF_WRAP_OFS, 32'h3);
    run(8'h1e, 4, 4'h3);
    slow <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      raw_val <= raws[j];
      for (int k = 0; k < 8; k++) begin
        apb(1'b1, ACF_FMT_OFS, {24'h0, 4'h1, 3'h0, 1'(k >> 2)});
        run({2'(k), 6'h0}, 1, 4'h3);
        chk_val({16'h0, result_word}, {16'h0, fexp(raws[j], 3'(k))});
      end
    end
    apb(1'b0, ACF_RAW_OFS, 32'h0);
    chk_val(rd, {22'h0, raws[2]});
    apb(1'b0, ACF_RES_OFS, 32'h0);
    chk_val(rd, {16'h0, fexp(raws[2], 3'h7)});
    apb(1'b0, ACF_STAT_OFS, 32'h0);
    chk_val(rd, 32'h0000_0001);
    // Start through the command register, stepping mode kept from control
    apb(1'b1, ACF_FMT_OFS, 32'h20);
    run(8'h10, 2, 4'h3);
    chq.delete();
    apb(1'b1, ACF_CMD_OFS, 32'h3);
    while (seq_busy === 1'b1) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    chk_val(32'(chq.size()), 32'h2);
    chk_chan(chq[0], 4'h3);
    chk_chan(chq[1], 4'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
